// ===== logic/card_win_pkg.sv
// constants for the card window address register bank
package card_win_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int NUM_IO      = 2;
   localparam int NUM_MEM     = 5;
   localparam int AXI_ADDR_W  = 8;
   localparam int AXI_DATA_W  = 32;
   localparam int IDX_W       = 6;
   localparam int WIN_ADDR_W  = 12;
   localparam int CARD_ADDR_W = 24;
   localparam int WIN_IDX_W   = 3;
   localparam int CYC_W       = 3;

   // ---------------------------------------------------------------
   // register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [IDX_W-1:0] IO_END_LOW_IDX [NUM_IO] =
      '{6'h0A, 6'h0E};
   localparam logic [IDX_W-1:0] IO_END_HIGH_IDX [NUM_IO] =
      '{6'h0B, 6'h0F};
   localparam logic [IDX_W-1:0] MEM_START_LOW_IDX [NUM_MEM] =
      '{6'h10, 6'h18, 6'h20, 6'h28, 6'h30};
   localparam logic [IDX_W-1:0] MEM_START_HIGH_IDX [NUM_MEM] =
      '{6'h11, 6'h19, 6'h21, 6'h29, 6'h31};
   localparam logic [IDX_W-1:0] MEM_END_LOW_IDX [NUM_MEM] =
      '{6'h12, 6'h1A, 6'h22, 6'h2A, 6'h32};
   localparam logic [IDX_W-1:0] MEM_END_HIGH_IDX [NUM_MEM] =
      '{6'h13, 6'h1B, 6'h23, 6'h2B, 6'h33};
   localparam logic [IDX_W-1:0] MEM_ENABLE_IDX = 6'h06;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int MEM_WIDTH_SELECT_BIT   = 7;
   localparam int SHORT_CYCLE_SELECT_BIT = 6;
   localparam int NIBBLE_MSB             = 3;
   localparam logic [7:0] END_HIGH_MASK  = 8'hCF;
   localparam logic [7:0] RESET_BYTE     = 8'h00;
   localparam logic [NUM_MEM-1:0] RESET_ENABLE = 5'h00;

   // ---------------------------------------------------------------
   // cycle lengths in ISA-equivalent cycles
   // ---------------------------------------------------------------
   localparam logic [CYC_W-1:0] STD_CYCLES_8    = 3'h6;
   localparam logic [CYC_W-1:0] STD_CYCLES_16   = 3'h3;
   localparam logic [CYC_W-1:0] SHORT_CYCLES_8  = 3'h3;
   localparam logic [CYC_W-1:0] SHORT_CYCLES_16 = 3'h2;

   // ---------------------------------------------------------------
   // bus responses
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : card_win_pkg

// ===== logic/card_window_address_regs.sv
// card window address registers with axi4-lite access and window decode
//
// Overview of operation
// - i/o window end low byte, reset zero
// - i/o window end high byte register
// - memory start low byte is A19-A12
// - start high bits 3-0 are A23-A20
// - start high bit 7 selects 16-bit width
// - short-cycle bit gives 8-bit three cycles
// - short-cycle bit gives 16-bit two cycles
// - bits 5-4 are plain scratch storage
// - window responds only while enable set
// - memory end address low and high bytes
`timescale 1ns/100ps
module card_window_address_regs
   import card_win_pkg::*;
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // axi4-lite slave
   input  wire logic [AXI_ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [AXI_DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0]  s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [AXI_DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // card access lookup from the cycle generator
   input  wire logic                   acc_valid,
   input  wire logic [CARD_ADDR_W-1:0] acc_addr,
   output logic                        acc_hit,
   output logic [WIN_IDX_W-1:0]        acc_window,
   output logic                        acc_wide,
   output logic                        acc_short,
   output logic [CYC_W-1:0]            acc_cycles,
   // i/o window end addresses
   output logic [15:0]                 io_win0_end,
   output logic [15:0]                 io_win1_end
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [7:0]          io_end_low_reg   [NUM_IO];
   logic [7:0]          io_end_high_reg  [NUM_IO];
   logic [7:0]          mem_start_low_reg  [NUM_MEM];
   logic [7:0]          mem_start_high_reg [NUM_MEM];
   logic [7:0]          mem_end_low_reg    [NUM_MEM];
   logic [7:0]          mem_end_high_reg   [NUM_MEM];
   logic [NUM_MEM-1:0]  mem_window_on_reg;

   // ---------------------------------------------------------------
   // bus state
   // ---------------------------------------------------------------
   logic                  aw_full_reg;
   logic                  aw_full_next;
   logic                  w_full_reg;
   logic                  w_full_next;
   logic [AXI_ADDR_W-1:0] aw_addr_reg;
   logic [7:0]            w_data_reg;
   logic                  w_lane0_reg;
   logic                  bvalid_reg;
   logic                  bvalid_next;
   logic [1:0]            bresp_reg;
   logic                  awready_reg;
   logic                  wready_reg;
   logic                  arready_reg;
   logic                  rvalid_reg;
   logic                  rvalid_next;
   logic [AXI_DATA_W-1:0] rdata_reg;
   logic [1:0]            rresp_reg;

   // ---------------------------------------------------------------
   // access outputs
   // ---------------------------------------------------------------
   logic                 acc_hit_reg;
   logic [WIN_IDX_W-1:0] acc_window_reg;
   logic                 acc_wide_reg;
   logic                 acc_short_reg;
   logic [CYC_W-1:0]     acc_cycles_reg;

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic [IDX_W-1:0] word_index
      (input logic [AXI_ADDR_W-1:0] byte_addr);
      word_index = byte_addr[AXI_ADDR_W-1:2];
   endfunction : word_index

   // returns {mapped, byte}; shared by the read path and write response
   function automatic logic [8:0] reg_lookup
      (input logic [IDX_W-1:0] idx);
      logic [8:0] res;
      res = {1'b0, RESET_BYTE};
      if (idx == MEM_ENABLE_IDX)
      begin
         res = {1'b1, 3'h0, mem_window_on_reg};
      end
      for (int i = 0; i < NUM_IO; i++)
      begin
         if (idx == IO_END_LOW_IDX[i])
         begin
            res = {1'b1, io_end_low_reg[i]};
         end
         if (idx == IO_END_HIGH_IDX[i])
         begin
            res = {1'b1, io_end_high_reg[i]};
         end
      end
      for (int i = 0; i < NUM_MEM; i++)
      begin
         if (idx == MEM_START_LOW_IDX[i])
         begin
            res = {1'b1, mem_start_low_reg[i]};
         end
         if (idx == MEM_START_HIGH_IDX[i])
         begin
            res = {1'b1, mem_start_high_reg[i]};
         end
         if (idx == MEM_END_LOW_IDX[i])
         begin
            res = {1'b1, mem_end_low_reg[i]};
         end
         if (idx == MEM_END_HIGH_IDX[i])
         begin
            res = {1'b1, mem_end_high_reg[i] & END_HIGH_MASK};
         end
      end
      reg_lookup = res;
   endfunction : reg_lookup

   function automatic logic [CYC_W-1:0] cycle_len
      (input logic wide, input logic short_sel);
      if (wide)
      begin
         cycle_len = short_sel ? SHORT_CYCLES_16 : STD_CYCLES_16;
      end
      else
      begin
         cycle_len = short_sel ? SHORT_CYCLES_8 : STD_CYCLES_8;
      end
   endfunction : cycle_len

   // ---------------------------------------------------------------
   // write channel
   // ---------------------------------------------------------------
   wire              aw_take  = s_axi_awvalid & awready_reg;
   wire              w_take   = s_axi_wvalid & wready_reg;
   wire              wr_fire  = aw_full_reg & w_full_reg;
   wire              b_done   = bvalid_reg & s_axi_bready;
   wire [IDX_W-1:0]  wr_idx   = word_index(aw_addr_reg);
   logic [8:0]       wr_look;
   wire              wr_en    = wr_fire & w_lane0_reg;

   // the lookup reads the register file itself, so it sits in always_comb,
   // whose sensitivity follows the function body; a wire would go stale
   always_comb wr_look = reg_lookup(wr_idx);

   assign aw_full_next = (aw_full_reg | aw_take) & ~wr_fire;
   assign w_full_next  = (w_full_reg | w_take) & ~wr_fire;
   assign bvalid_next  = wr_fire | (bvalid_reg & ~s_axi_bready);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         aw_addr_reg <= '0;
         w_data_reg  <= RESET_BYTE;
         w_lane0_reg <= 1'b0;
      end
      else
      begin
         aw_full_reg <= aw_full_next;
         w_full_reg  <= w_full_next;
         awready_reg <= ~aw_full_next & ~bvalid_next;
         wready_reg  <= ~w_full_next & ~bvalid_next;
         bvalid_reg  <= bvalid_next;
         if (aw_take)
         begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_take)
         begin
            w_data_reg  <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
         end
         if (wr_fire)
         begin
            bresp_reg <= wr_look[8] ? RESP_OKAY : RESP_DECERR;
         end
      end
   end

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   // i/o end low and high bytes
   generate
      for (genvar i = 0; i < NUM_IO; i++)
      begin : g_io
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               io_end_low_reg[i]  <= RESET_BYTE;
               io_end_high_reg[i] <= RESET_BYTE;
            end
            else if (wr_en && wr_idx == IO_END_LOW_IDX[i])
            begin
               io_end_low_reg[i] <= w_data_reg;
            end
            else if (wr_en && wr_idx == IO_END_HIGH_IDX[i])
            begin
               io_end_high_reg[i] <= w_data_reg;
            end
         end
      end
   endgenerate

   generate
      for (genvar i = 0; i < NUM_MEM; i++)
      begin : g_mem
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               mem_start_low_reg[i]  <= RESET_BYTE;
               mem_start_high_reg[i] <= RESET_BYTE;
               mem_end_low_reg[i]    <= RESET_BYTE;
               mem_end_high_reg[i]   <= RESET_BYTE;
            end
            else if (wr_en)
            begin
               if (wr_idx == MEM_START_LOW_IDX[i])
               begin
                  mem_start_low_reg[i] <= w_data_reg;
               end
               if (wr_idx == MEM_START_HIGH_IDX[i])
               begin
                  mem_start_high_reg[i] <= w_data_reg;
               end
               if (wr_idx == MEM_END_LOW_IDX[i])
               begin
                  mem_end_low_reg[i] <= w_data_reg;
               end
               if (wr_idx == MEM_END_HIGH_IDX[i])
               begin
                  mem_end_high_reg[i] <= w_data_reg & END_HIGH_MASK;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mem_window_on_reg <= RESET_ENABLE;
      end
      else if (wr_en && wr_idx == MEM_ENABLE_IDX)
      begin
         mem_window_on_reg <= w_data_reg[NUM_MEM-1:0];
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   wire              ar_take = s_axi_arvalid & arready_reg;
   logic [8:0]       rd_look;

   always_comb rd_look = reg_lookup(word_index(s_axi_araddr));

   assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
      end
      else
      begin
         arready_reg <= ~rvalid_next;
         rvalid_reg  <= rvalid_next;
         if (ar_take)
         begin
            rdata_reg <= {24'h000000, rd_look[7:0]};
            rresp_reg <= rd_look[8] ? RESP_OKAY : RESP_DECERR;
         end
      end
   end

   // ---------------------------------------------------------------
   // window decode
   // ---------------------------------------------------------------
   win_cfg_if            cfg ();
   logic                 dec_hit;
   logic [WIN_IDX_W-1:0] dec_index;

   generate
      for (genvar i = 0; i < NUM_MEM; i++)
      begin : g_cfg
         assign cfg.start_addr[i] = {mem_start_high_reg[i][NIBBLE_MSB:0],
                                     mem_start_low_reg[i]};
         assign cfg.end_addr[i]   = {mem_end_high_reg[i][NIBBLE_MSB:0],
                                     mem_end_low_reg[i]};
      end
   endgenerate
   assign cfg.mem_window_on = mem_window_on_reg;

   window_decode u_decode (
      .cfg       (cfg.dec),
      .page_addr (acc_addr[CARD_ADDR_W-1:CARD_ADDR_W-WIN_ADDR_W]),
      .any_hit   (dec_hit),
      .hit_index (dec_index)
   );

   wire [7:0] hit_high  = mem_start_high_reg[dec_index];
   wire       hit_wide  = hit_high[MEM_WIDTH_SELECT_BIT];
   wire       hit_short = hit_high[SHORT_CYCLE_SELECT_BIT];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         acc_hit_reg    <= 1'b0;
         acc_window_reg <= '0;
         acc_wide_reg   <= 1'b0;
         acc_short_reg  <= 1'b0;
         acc_cycles_reg <= STD_CYCLES_8;
      end
      else
      begin
         acc_hit_reg    <= acc_valid & dec_hit;
         acc_window_reg <= dec_index;
         acc_wide_reg   <= hit_wide;
         acc_short_reg  <= hit_short;
         acc_cycles_reg <= cycle_len(hit_wide, hit_short);
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign acc_hit       = acc_hit_reg;
   assign acc_window    = acc_window_reg;
   assign acc_wide      = acc_wide_reg;
   assign acc_short     = acc_short_reg;
   assign acc_cycles    = acc_cycles_reg;
   assign io_win0_end   = {io_end_high_reg[0], io_end_low_reg[0]};
   assign io_win1_end   = {io_end_high_reg[1], io_end_low_reg[1]};

endmodule : card_window_address_regs

// ===== logic/win_cfg_if.sv
// memory window settings passed from the register bank to the decoder
`timescale 1ns/100ps
interface win_cfg_if;
   import card_win_pkg::*;

   logic [NUM_MEM-1:0][WIN_ADDR_W-1:0] start_addr;
   logic [NUM_MEM-1:0][WIN_ADDR_W-1:0] end_addr;
   logic [NUM_MEM-1:0]                 mem_window_on;

   modport src (output start_addr, output end_addr, output mem_window_on);
   modport dec (input start_addr, input end_addr, input mem_window_on);

endinterface : win_cfg_if

// ===== logic/window_decode.sv
// address range match over the five memory windows
`timescale 1ns/100ps
module window_decode
   import card_win_pkg::*;
(
   win_cfg_if.dec                    cfg,
   input  wire logic [WIN_ADDR_W-1:0] page_addr,
   output logic                      any_hit,
   output logic [WIN_IDX_W-1:0]      hit_index
);

   logic [NUM_MEM-1:0] hits;

   // ---------------------------------------------------------------
   // per-window compare
   // ---------------------------------------------------------------
   // enable gates match
   generate
      for (genvar i = 0; i < NUM_MEM; i++)
      begin : g_cmp
         assign hits[i] = cfg.mem_window_on[i]
                        & (page_addr >= cfg.start_addr[i])
                        & (page_addr <= cfg.end_addr[i]);
      end
   endgenerate

   // ---------------------------------------------------------------
   // priority select
   // ---------------------------------------------------------------
   // overlapping windows resolve to the lowest numbered one
   always_comb
   begin
      hit_index = '0;
      for (int i = NUM_MEM - 1; i >= 0; i--)
      begin
         if (hits[i])
         begin
            hit_index = WIN_IDX_W'(i);
         end
      end
   end

   assign any_hit = |hits;

endmodule : window_decode

// ===== test/card_window_address_regs_sva.sv
// port-level checks for the card window register bank
`timescale 1ns/100ps
module card_window_address_regs_sva
   import card_win_pkg::*;
(
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic [1:0]            s_axi_bresp,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
   input wire logic                  s_axi_rvalid,
   input wire logic                  acc_valid,
   input wire logic                  acc_hit,
   input wire logic                  acc_wide,
   input wire logic                  acc_short,
   input wire logic [CYC_W-1:0]      acc_cycles,
   input wire logic [15:0]           io_win0_end
);
   // ----------
   // assertions
   // ----------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_write_answer:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_aw_refused:
   assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address taken too soon");
   a_ar_refused:
   assert property (s_axi_arvalid && s_axi_arready
      |=> !s_axi_arready && s_axi_rvalid)
      else $error("second read address taken too soon");
   a_rdata_upper:
   assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read data bits not zero");
   a_hit_cause:
   assert property (acc_hit |-> $past(acc_valid))
      else $error("hit without a lookup request");
   a_short_eight:
   assert property (acc_hit && acc_short && !acc_wide
      |-> acc_cycles == SHORT_CYCLES_8)
      else $error("short 8-bit cycle length wrong");
   a_short_sixteen:
   assert property (acc_hit && acc_short && acc_wide
      |-> acc_cycles == SHORT_CYCLES_16)
      else $error("short 16-bit cycle length wrong");
   a_std_length:
   assert property (acc_hit && !acc_short |-> acc_cycles ==
      (acc_wide ? STD_CYCLES_16 : STD_CYCLES_8))
      else $error("standard cycle length wrong");
   a_io_end_write:
   assert property ($changed(io_win0_end) |-> $rose(s_axi_bvalid))
      else $error("io end address moved without a write");

   cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
   cover property (acc_hit && acc_short && acc_wide);
   cover property (acc_hit && !acc_short && !acc_wide);
endmodule : card_window_address_regs_sva

bind card_window_address_regs card_window_address_regs_sva u_sva (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .acc_valid, .acc_hit,
   .acc_wide, .acc_short, .acc_cycles, .io_win0_end);

// ===== test/card_window_address_regs_test.sv
// self-checking bench for the card window register bank
`timescale 1ns/100ps
module card_window_address_regs_test
   import card_win_pkg::*;
;
   logic        aclk, aresetn;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, acc_valid, acc_hit;
   logic        acc_wide, acc_short;
   logic [23:0] acc_addr;
   logic [2:0]  acc_window, acc_cycles;
   logic [15:0] io_win0_end, io_win1_end;
   int          error_cnt, comparisons;

   card_window_address_regs u_dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .acc_valid, .acc_addr, .acc_hit,
      .acc_window, .acc_wide, .acc_short, .acc_cycles, .io_win0_end,
      .io_win1_end);

   // -------
   // helpers
   // -------
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic timeout(input int n);
      if (n >= 40)
      begin
         error_cnt++;
         $display("unexpected wait: expected below 40 seen %0d", n);
         end_of_test();
      end
   endtask : timeout

   // the fourteen registers of the table, in table order
   function automatic logic [7:0] reg_addr(input int k);
      logic [5:0] i;
      if (k < 2) i = IO_END_LOW_IDX[k];
      else if (k < 4) i = IO_END_HIGH_IDX[k-2];
      else if (k < 9) i = MEM_START_LOW_IDX[k-4];
      else i = MEM_START_HIGH_IDX[k-9];
      return {i, 2'b00};
   endfunction : reg_addr

   function automatic logic [7:0] pat(input int k);
      return 8'hA5 ^ 8'(k * 29);
   endfunction : pat

   task automatic bus_wr(input logic [7:0] a, d, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 40);
      s_axi_bready <= 1'b0;
      timeout(n);
      check("bresp", er, s_axi_bresp);
      @(posedge aclk);
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, ed, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 40);
      s_axi_rready <= 1'b0;
      timeout(n);
      check("rresp", er, s_axi_rresp);
      if (er === RESP_OKAY) check("rdata", {24'h0, ed}, s_axi_rdata);
      @(posedge aclk);
   endtask : bus_rd

   // ws is {wide, short} expected of the hitting window
   task automatic look(input logic [23:0] a, input logic h,
                       input logic [2:0] w, input logic [1:0] ws);
      logic [2:0] cyc;
      cyc = ws[1] ? (ws[0] ? SHORT_CYCLES_16 : STD_CYCLES_16)
                  : (ws[0] ? SHORT_CYCLES_8 : STD_CYCLES_8);
      acc_addr  <= a;
      acc_valid <= 1'b1;
      @(posedge aclk);
      acc_valid <= 1'b0;
      @(posedge aclk);
      check("acc_hit", h, acc_hit);
      if (h)
      begin
         check("acc_window", w, acc_window);
         check("acc_wide", ws[1], acc_wide);
         check("acc_short", ws[0], acc_short);
         check("acc_cycles", cyc, acc_cycles);
      end
   endtask : look

   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : do_reset

   // ---------
   // scenarios
   // ---------
   task automatic t_reset_vals;
      for (int k = 0; k < 14; k++)
         bus_rd(reg_addr(k), 8'h00, RESP_OKAY);
      check("io_win1_end", 16'h0000, io_win1_end);
      $display("test reset values done");
   endtask : t_reset_vals

   task automatic t_readback;
      for (int k = 0; k < 14; k++)
         bus_wr(reg_addr(k), pat(k), RESP_OKAY);
      for (int k = 0; k < 14; k++)
         bus_rd(reg_addr(k), pat(k), RESP_OKAY);
      check("io_win0_end", {pat(2), pat(0)}, io_win0_end);
      check("io_win1_end", {pat(3), pat(1)}, io_win1_end);
      // a write with no byte lane enabled must leave the register alone
      s_axi_wstrb <= 4'h0;
      bus_wr(reg_addr(0), 8'hFF, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      bus_rd(reg_addr(0), pat(0), RESP_OKAY);
      bus_wr(8'hFC, 8'h5A, RESP_DECERR);
      bus_rd(8'hFC, 8'h00, RESP_DECERR);
      bus_wr({MEM_END_HIGH_IDX[0], 2'b00}, 8'hFF, RESP_OKAY);
      bus_rd({MEM_END_HIGH_IDX[0], 2'b00}, END_HIGH_MASK, RESP_OKAY);
      $display("test readback done");
   endtask : t_readback

   task automatic t_decode;
      logic [7:0] en, hb;
      en = {MEM_ENABLE_IDX, 2'b00};
      bus_wr(reg_addr(6), 8'h23, RESP_OKAY);
      bus_wr(reg_addr(11), 8'h01, RESP_OKAY);
      bus_wr({MEM_END_LOW_IDX[2], 2'b00}, 8'h25, RESP_OKAY);
      bus_wr({MEM_END_HIGH_IDX[2], 2'b00}, 8'h01, RESP_OKAY);
      bus_wr(en, 8'h00, RESP_OKAY);
      look(24'h123000, 1'b0, 3'h0, 2'h0);
      bus_wr(en, 8'h04, RESP_OKAY);
      // scratch bits follow bit 2 of m and must not change the answer
      for (int m = 0; m < 8; m++)
      begin
         hb = {m[1], m[0], m[2], m[2], 4'h1};
         bus_wr(reg_addr(11), hb, RESP_OKAY);
         look(24'h123000, 1'b1, 3'h2, 2'(m));
      end
      look(24'h125FFF, 1'b1, 3'h2, 2'h3);
      look(24'h126000, 1'b0, 3'h0, 2'h0);
      look(24'h122FFF, 1'b0, 3'h0, 2'h0);
      look(24'h023000, 1'b0, 3'h0, 2'h0);
      bus_wr(reg_addr(4), 8'h00, RESP_OKAY);
      bus_wr(reg_addr(9), 8'h00, RESP_OKAY);
      bus_wr({MEM_END_LOW_IDX[0], 2'b00}, 8'hFF, RESP_OKAY);
      bus_wr({MEM_END_HIGH_IDX[0], 2'b00}, 8'h0F, RESP_OKAY);
      bus_wr(en, 8'h05, RESP_OKAY);
      look(24'h124000, 1'b1, 3'h0, 2'h0);
      look(24'hFFF000, 1'b1, 3'h0, 2'h0);
      $display("test decode done");
   endtask : t_decode

   initial
   begin
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_awprot = 3'h0;
      s_axi_arprot = 3'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      acc_valid = 1'b0;
      acc_addr = 24'h000000;
      error_cnt = 0;
      comparisons = 0;
      do_reset();
      t_reset_vals();
      t_readback();
      t_decode();
      do_reset();
      t_reset_vals();
      end_of_test();
   end
endmodule : card_window_address_regs_test
